// ==== logic/prt_pkg.sv ====
// Shared constants and types of the prescaled reload timer
`default_nettype none
package prt_pkg;
    // ************************************************************
    // Register map: word indices, byte address is index times four
    // ************************************************************
    localparam int unsigned IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_CTRL = 10'h100;
    localparam logic [IDX_W-1:0] IDX_IOC = 10'h101;
    localparam logic [IDX_W-1:0] IDX_MODE = 10'h102;
    localparam logic [IDX_W-1:0] IDX_PRE = 10'h103;
    localparam logic [IDX_W-1:0] IDX_TMR = 10'h104;
    localparam int unsigned IDX_LSB = 2;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned CTL_START = 0;
    localparam int unsigned CTL_STAT = 1;
    localparam int unsigned CTL_STOP = 2;
    localparam int unsigned CTL_EDGF = 4;
    localparam int unsigned CTL_UNDF = 5;
    localparam int unsigned IOC_POL = 0;
    localparam int unsigned IOC_OUTC = 1;
    localparam int unsigned IOC_INVEN = 2;
    localparam int unsigned IOC_SEL = 3;
    localparam int unsigned IOC_FLT_LO = 4;
    localparam int unsigned IOC_FLT_HI = 5;
    localparam int unsigned MOD_LO = 0;
    localparam int unsigned MOD_HI = 2;
    localparam int unsigned SRC_LO = 4;
    localparam int unsigned SRC_HI = 6;

    // ************************************************************
    // Widths, masks and reset values
    // ************************************************************
    localparam int unsigned STAGE_W = 8;
    localparam logic [7:0] IOC_MASK = 8'h3F;
    localparam logic [7:0] MODE_MASK = 8'h77;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [STAGE_W-1:0] STAGE_PRESET = 8'hFF;
    localparam logic [STAGE_W-1:0] STAGE_ZERO = 8'h00;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam logic [1:0] FLT_OFF = 2'h0;
    localparam int unsigned HTRANS_ACT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    // Count source choices
    typedef enum logic [2:0] {
        SRC_DIV1 = 3'h0,
        SRC_DIV8 = 3'h1,
        SRC_OSC = 3'h2,
        SRC_DIV2 = 3'h3,
        SRC_SUB32 = 3'h4
    } prt_src_t;

    // Operating mode codes
    typedef enum logic [2:0] {
        MODE_TIMER = 3'h0,
        MODE_PULSE = 3'h1,
        MODE_EVENT = 3'h2,
        MODE_WIDTH = 3'h3,
        MODE_PERIOD = 3'h4
    } prt_mode_t;

    // Bus read sequencing, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_FETCH = 2'b10
    } prt_bus_st_t;
endpackage
`default_nettype wire

// ==== logic/prt_stage_if.sv ====
// Carrier between the timer core and one reload/counter stage
`timescale 1ns/1ps
`default_nettype none
interface prt_stage_if;
    import prt_pkg::*;
    logic wr; // Bus write to this stage
    logic wr_now; // Write reaches counter at once
    logic [STAGE_W-1:0] wdata; // Written value
    logic step; // Count enable pulse
    logic force_stop; // Preset both halves
    logic [STAGE_W-1:0] cnt; // Counter value
    logic uf; // Underflow this cycle
    modport stage(input wr, wr_now, wdata, step, force_stop,
        output cnt, uf);
    modport ctrl(output wr, wr_now, wdata, step, force_stop,
        input cnt, uf);
endinterface
`default_nettype wire

// ==== logic/prt_stage.sv ====
// One down-counting stage: reload register plus counter
`timescale 1ns/1ps
`default_nettype none
module prt_stage
    import prt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Core side
    prt_stage_if.stage s
);
    logic [STAGE_W-1:0] reload_q; // Reload register
    logic [STAGE_W-1:0] cnt_q; // Counter
    logic pend_q; // Write waits for a count step

    assign s.cnt = cnt_q;
    // [R24] Underflow at zero
    assign s.uf = s.step && (cnt_q == STAGE_ZERO);

    // ************************************************************
    // Reload and count
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reload_q <= STAGE_PRESET;
            cnt_q <= STAGE_PRESET;
            pend_q <= 1'b0;
        end else if (ce) begin
            if (s.force_stop) begin
                // [R06] [R07] Preset all ones
                reload_q <= STAGE_PRESET;
                cnt_q <= STAGE_PRESET;
                pend_q <= 1'b0;
            end else if (s.wr) begin
                // [R20] Stopped write loads both
                reload_q <= s.wdata;
                if (s.wr_now) begin
                    cnt_q <= s.wdata;
                end
                pend_q <= !s.wr_now;
            end else if (s.step) begin
                // [R14] Reload or decrement
                if (pend_q || cnt_q == STAGE_ZERO) begin
                    cnt_q <= reload_q;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
                pend_q <= 1'b0;
            end
        end
    end
endmodule // prt_stage
`default_nettype wire

// ==== logic/prt_tick_gen.sv ====
// Count source selection and tick generation
`timescale 1ns/1ps
`default_nettype none
module prt_tick_gen
    import prt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Selection
    input wire prt_src_t sel,
    // Asynchronous source pins
    input wire logic osc_pin,
    input wire logic sub_pin,
    // One-cycle count source pulse
    output logic tick
);
    logic [2:0] div_q; // Free-running system clock divider
    logic [2:0] osc_q; // Sync pair plus edge history
    logic [2:0] sub_q; // Sync pair plus edge history

    // ************************************************************
    // Divider and synchronisers
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= DIV_RESET;
            osc_q <= DIV_RESET;
            sub_q <= DIV_RESET;
        end else if (ce) begin
            div_q <= div_q + 1'b1;
            osc_q <= {osc_q[1:0], osc_pin};
            sub_q <= {sub_q[1:0], sub_pin};
        end
    end

    // [R13] Source select
    always_comb begin
        case (sel)
            SRC_DIV1: tick = 1'b1;
            SRC_DIV2: tick = div_q[0];
            SRC_DIV8: tick = (div_q == DIV8_LAST);
            // Rising edges seen after the second flip-flop only
            SRC_OSC: tick = osc_q[1] && !osc_q[2];
            SRC_SUB32: tick = sub_q[1] && !sub_q[2];
            default: tick = 1'b0;
        endcase
    end
endmodule // prt_tick_gen
`default_nettype wire

// ==== logic/prt_timer_top.sv ====
// Prescaled reload timer with AHB-Lite register slave
//
// Functional notes
// [R01] Eight-bit timer behind eight-bit prescaler
// [R02] Reload and counter share one address
// [R03] Selected count source times all counting
// [R04] Five mode codes held, timer behaviour
// [R05] Forced stop restores start, status, stages
// [R06] Forced stop presets prescaler to ones
// [R07] Forced stop presets timer to ones
// [R08] Flags clear only by writing zero
// [R09] Software writes whole control register
// [R10] Mode rewritten only while fully stopped
// [R11] I/O control holds polarity, output, filter
// [R12] Upper two I/O control bits read zero
// [R13] Five selectable count sources
// [R14] Down count, reload on underflow
// [R15] Period is source times (n+1)(m+1)
// [R16] Writing start one begins counting
// [R17] Start zero or forced stop halts
// [R18] Interrupt request on each timer underflow
// [R19] Reads return live counter values
// [R20] Stopped write loads reload and counter
// [R21] Timer pin is port or irq input
// [R22] Timer steps on prescaler underflow
// [R23] Prescaler picks write up on source tick
// [R24] Underflow and reload at zero
`timescale 1ns/1ps
`default_nettype none
module prt_timer_top
    import prt_pkg::*;
(
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Count source pins
    input wire logic onchip_osc_clock,
    input wire logic subclock_div32,
    // Timer pins
    input wire logic timer_io_pin_i,
    output logic timer_io_pin_o,
    output logic timer_io_pin_oe,
    output logic timer_aux_output_pin_o,
    output logic timer_aux_output_pin_oe,
    // Requests
    output logic external_irq_one,
    output logic timer_irq
);
    // ************************************************************
    // Declarations
    // ************************************************************
    prt_stage_if pre_if (); // Prescaler stage
    prt_stage_if tmr_if (); // Timer stage
    prt_bus_st_t bus_q; // Read sequencing
    logic dph_q; // Write data phase pending
    logic [IDX_W-1:0] idx_q; // Latched word index
    logic count_start_bit_q; // Start request
    logic count_status_flag_q; // Counting really active
    logic active_edge_flag_q; // Sticky edge flag
    logic underflow_flag_q; // Sticky underflow flag
    logic [7:0] ioc_q; // I/O control register
    logic [7:0] mode_q; // Mode register
    logic [2:0] pin_q; // Pin sync pair plus filter stage
    logic irq_pin_q; // Filtered, polarity-adjusted pin
    logic tick; // Selected count source pulse
    logic addr_ok; // Address phase taken
    logic wr_ctrl, wr_ioc, wr_mode; // Register writes
    logic force_stop; // Forced stop this cycle

    // Word index decode, shared by reads and writes
    function automatic logic [IDX_W-1:0] word_idx(logic [31:0] a);
        return a[IDX_LSB +: IDX_W];
    endfunction

    assign addr_ok = hsel && hready && htrans[HTRANS_ACT];
    assign wr_ctrl = dph_q && idx_q == IDX_CTRL;
    assign wr_ioc = dph_q && idx_q == IDX_IOC;
    assign wr_mode = dph_q && idx_q == IDX_MODE;
    // [R05] Forced stop request
    assign force_stop = wr_ctrl && hwdata[CTL_STOP];

    // ************************************************************
    // Bus address phase and read sequencing
    // ************************************************************
    // Reads take one wait state so a write just before is visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_q <= BUS_IDLE;
            dph_q <= 1'b0;
            idx_q <= '0;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else if (ce) begin
            hresp <= HRESP_OKAY;
            case (bus_q)
                BUS_IDLE: begin
                    dph_q <= addr_ok && hwrite;
                    if (addr_ok) begin
                        idx_q <= word_idx(haddr);
                    end
                    if (addr_ok && !hwrite) begin
                        bus_q <= BUS_FETCH;
                        hreadyout <= 1'b0;
                    end
                end
                BUS_FETCH: begin
                    bus_q <= BUS_IDLE;
                    hreadyout <= 1'b1;
                end
                default: begin
                    bus_q <= BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (ce && bus_q == BUS_FETCH) begin
            hrdata <= '0;
            case (idx_q)
                IDX_CTRL: begin
                    hrdata[CTL_START] <= count_start_bit_q;
                    hrdata[CTL_STAT] <= count_status_flag_q;
                    hrdata[CTL_EDGF] <= active_edge_flag_q;
                    hrdata[CTL_UNDF] <= underflow_flag_q;
                end
                // [R12] Upper bits read zero
                IDX_IOC: hrdata[7:0] <= ioc_q & IOC_MASK;
                IDX_MODE: hrdata[7:0] <= mode_q;
                // [R19] Live counter values
                IDX_PRE: hrdata[7:0] <= pre_if.cnt;
                IDX_TMR: hrdata[7:0] <= tmr_if.cnt;
                // Unmapped words read zero
                default: hrdata <= '0;
            endcase
        end
    end

    // ************************************************************
    // Start and status
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_start_bit_q <= 1'b0;
            count_status_flag_q <= 1'b0;
        end else if (ce) begin
            if (force_stop) begin
                // [R17] Forced stop halts
                count_start_bit_q <= 1'b0;
                count_status_flag_q <= 1'b0;
            end else begin
                if (wr_ctrl) begin
                    // [R16] Start or stop by software
                    count_start_bit_q <= hwdata[CTL_START];
                end
                // Status follows start in step with the source
                if (tick) begin
                    count_status_flag_q <= count_start_bit_q;
                end
            end
        end
    end

    // ************************************************************
    // Sticky flags
    // ************************************************************
    // A new underflow beats a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_edge_flag_q <= 1'b0;
            underflow_flag_q <= 1'b0;
        end else if (ce) begin
            // [R08] Clear on zero only
            if (wr_ctrl && !hwdata[CTL_EDGF]) begin
                active_edge_flag_q <= 1'b0;
            end
            if (tmr_if.uf) begin
                underflow_flag_q <= 1'b1;
            end else if (wr_ctrl && !hwdata[CTL_UNDF]) begin
                underflow_flag_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // I/O control and mode registers
    // ************************************************************
    // Mode changes are trusted to come only while stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ioc_q <= REG_RESET;
            mode_q <= REG_RESET;
        end else if (ce) begin
            if (wr_ioc) begin
                // [R11] Polarity, output, filter fields
                ioc_q <= hwdata[7:0] & IOC_MASK;
            end
            if (wr_mode) begin
                // [R04] Mode code stored
                mode_q <= hwdata[7:0] & MODE_MASK;
            end
        end
    end

    // ************************************************************
    // Count source and stages
    // ************************************************************
    // [R03] Source drives both stages
    prt_tick_gen u_tick (
        .clk(hclk),
        .rstn(hresetn),
        .ce(ce),
        .sel(prt_src_t'(mode_q[SRC_HI:SRC_LO])),
        .osc_pin(onchip_osc_clock),
        .sub_pin(subclock_div32),
        .tick(tick)
    );

    // [R02] One address per stage
    assign pre_if.wr = dph_q && idx_q == IDX_PRE;
    assign tmr_if.wr = dph_q && idx_q == IDX_TMR;
    assign pre_if.wdata = hwdata[STAGE_W-1:0];
    assign tmr_if.wdata = hwdata[STAGE_W-1:0];
    // [R20] Direct load only when stopped
    assign pre_if.wr_now = !count_start_bit_q && !count_status_flag_q;
    assign tmr_if.wr_now = !count_start_bit_q && !count_status_flag_q;
    assign pre_if.force_stop = force_stop;
    assign tmr_if.force_stop = force_stop;
    // [R23] Prescaler steps on source ticks
    assign pre_if.step = count_status_flag_q && tick;
    // [R22] Timer steps on prescaler underflow
    assign tmr_if.step = pre_if.uf;

    // [R01] Prescaler stage
    prt_stage u_pre (
        .clk(hclk),
        .rstn(hresetn),
        .ce(ce),
        .s(pre_if)
    );

    // [R15] Chained stages give (n+1)(m+1)
    prt_stage u_tmr (
        .clk(hclk),
        .rstn(hresetn),
        .ce(ce),
        .s(tmr_if)
    );

    // ************************************************************
    // Pins and requests
    // ************************************************************
    // Filter trades one extra cycle of latency for glitch immunity
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_q <= '0;
            irq_pin_q <= 1'b0;
            external_irq_one <= 1'b0;
            timer_irq <= 1'b0;
            timer_io_pin_o <= 1'b0;
            timer_io_pin_oe <= 1'b0;
            timer_aux_output_pin_o <= 1'b0;
            timer_aux_output_pin_oe <= 1'b0;
        end else if (ce) begin
            pin_q <= {pin_q[1:0], timer_io_pin_i};
            if (ioc_q[IOC_FLT_HI:IOC_FLT_LO] == FLT_OFF ||
                pin_q[1] == pin_q[2]) begin
                irq_pin_q <= pin_q[1] ^ ioc_q[IOC_POL];
            end
            // [R21] Pin feeds irq while the select bit is zero
            external_irq_one <= irq_pin_q && !ioc_q[IOC_SEL];
            // [R18] Request per underflow
            timer_irq <= tmr_if.uf;
            // Timer mode leaves both pins to the port logic
            timer_io_pin_o <= 1'b0;
            timer_io_pin_oe <= 1'b0;
            timer_aux_output_pin_o <= 1'b0;
            timer_aux_output_pin_oe <= 1'b0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_force_presets: assert property ( // [R07]
        ce && force_stop |=> tmr_if.cnt == STAGE_PRESET &&
            pre_if.cnt == STAGE_PRESET && !count_start_bit_q)
        else $error("forced stop did not preset stages");
    a_start_begins: assert property ( // [R16]
        ce && wr_ctrl && hwdata[CTL_START] && !force_stop
            |=> count_start_bit_q)
        else $error("start bit not set by write");
    a_flag_keeps: assert property ( // [R08]
        ce && underflow_flag_q && wr_ctrl && hwdata[CTL_UNDF]
            |=> underflow_flag_q)
        else $error("underflow flag lost on write of one");
    a_underflow_sets: assert property ( // [R18]
        ce && tmr_if.uf |=> underflow_flag_q && timer_irq)
        else $error("underflow did not raise flag and request");
    a_irq_cause: assert property ( // [R18]
        timer_irq |-> $past(tmr_if.uf))
        else $error("request without underflow");
    a_ioc_upper: assert property ( // [R12]
        ce && bus_q == BUS_FETCH && idx_q == IDX_IOC
            |=> hrdata[7:6] == 2'h0)
        else $error("upper control bits read nonzero");
    a_stop_write: assert property ( // [R20]
        ce && pre_if.wr && pre_if.wr_now && !force_stop
            |=> pre_if.cnt == $past(hwdata[STAGE_W-1:0]))
        else $error("stopped write missed counter");
    a_idle_hold: assert property ( // [R17]
        ce && !count_status_flag_q && !pre_if.wr && !tmr_if.wr &&
            !force_stop |=> $stable(tmr_if.cnt))
        else $error("timer moved while stopped");
    a_timer_step: assert property ( // [R22]
        ce && !pre_if.uf && !tmr_if.wr && !force_stop
            |=> $stable(tmr_if.cnt))
        else $error("timer moved without prescaler underflow");
    a_read_wait: assert property ( // [R19]
        ce && bus_q == BUS_IDLE && addr_ok && !hwrite
            |=> !hreadyout ##1 (hreadyout || !ce))
        else $error("read wait state wrong");

    c_underflow: cover property (tmr_if.uf);
    c_force_stop: cover property (ce && force_stop);
    c_flag_race: cover property (tmr_if.uf && wr_ctrl);
    c_reload_chain: cover property (pre_if.uf ##[1:20] pre_if.uf);
endmodule // prt_timer_top
`default_nettype wire

// ==== verif/prt_timer_top_tb.sv ====
// Self-checking testbench of the prescaled reload timer
`timescale 1ns/1ps
`default_nettype none
module prt_timer_top_tb
    import prt_pkg::*;
;
    // ************************************************************
    // Signals
    // ************************************************************
    logic hclk; // Bus clock
    logic hresetn; // Active low reset
    logic hsel;
    logic hwrite;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd; // Last read word
    logic hreadyout;
    logic hresp;
    logic osc; // Count source pins
    logic sub;
    logic pin_i; // Timer pin input
    logic irq1;
    logic tirq;
    logic [3:0] pins; // Pin drivers, idle in timer mode
    logic [7:0] rnd; // Random state
    logic [2:0] n;
    logic [2:0] m;
    int err_total;
    int checks_done;
    int oc;
    int sc;
    int cyc; // Cycles spent waiting

    prt_timer_top dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .onchip_osc_clock(osc), .subclock_div32(sub),
        .timer_io_pin_i(pin_i), .timer_io_pin_o(pins[0]),
        .timer_io_pin_oe(pins[1]), .timer_aux_output_pin_o(pins[2]),
        .timer_aux_output_pin_oe(pins[3]),
        .external_irq_one(irq1), .timer_irq(tirq));

    // ************************************************************
    // Clock and slow source pins
    // ************************************************************
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // Oscillator pin period 6 cycles, sub-clock pin period 10
    always @(posedge hclk) begin
        oc <= (oc == 2) ? 0 : oc + 1;
        sc <= (sc == 4) ? 0 : sc + 1;
        if (oc == 2) osc <= ~osc;
        if (sc == 4) sub <= ~sub;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Expected underflow spacing in bus clock cycles
    function automatic int per(input int src, input int pn, input int tm);
        int d;
        case (src)
            0: d = 1;
            3: d = 2;
            1: d = 8;
            2: d = 6;
            default: d = 10;
        endcase
        return d * (pn + 1) * (tm + 1);
    endfunction

    // One single transfer; called just after a rising edge
    task automatic bus(input logic w, input logic [9:0] idx,
        input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask

    // Bounded wait for the next request pulse
    task automatic wait_irq();
        cyc = 0;
        do begin
            @(posedge hclk);
            cyc++;
        end while (tirq !== 1'b1 && cyc < 4000);
    endtask

    task automatic stop_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog well above the longest expected run
    initial begin
        repeat (60000) @(posedge hclk);
        err_total++;
        stop_test();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        osc = 1'b0;
        sub = 1'b0;
        pin_i = 1'b0;
        oc = 0;
        sc = 0;
        rnd = 8'h30;
        err_total = 0;
        checks_done = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(IDX_PRE, 32'hFF); // preset
        rdchk(IDX_TMR, 32'hFF); // preset
        bus(1'b1, 10'h1FF, 8'hFF);
        rdchk(10'h1FF, 32'h0); // unmapped
        bus(1'b1, IDX_IOC, 8'hFF);
        rdchk(IDX_IOC, 32'h3F); // upper zero
        // Pin high, no filter, then inverted, then routed away
        pin_i <= 1'b1;
        bus(1'b1, IDX_IOC, 8'h00);
        repeat (6) @(posedge hclk);
        chk({31'h0, irq1}, 32'h1); // irq input
        bus(1'b1, IDX_IOC, 8'h01);
        repeat (6) @(posedge hclk);
        chk({31'h0, irq1}, 32'h0); // polarity
        bus(1'b1, IDX_IOC, 8'h08);
        repeat (6) @(posedge hclk);
        chk({31'h0, irq1}, 32'h0); // select
        // One-cycle low glitch must not pass the enabled filter
        bus(1'b1, IDX_IOC, 8'h10);
        pin_i <= 1'b0;
        @(posedge hclk);
        pin_i <= 1'b1;
        repeat (6) begin
            @(posedge hclk);
            chk({31'h0, irq1}, 32'h1); // filter
        end
        chk({27'h0, hresp, pins}, 32'h0); // pins idle, OKAY
        // Every source and mode code, last pass is the fastest corner
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            n = (i == 5) ? 3'h0 : rnd[2:0];
            m = (i == 5) ? 3'h0 : rnd[5:3];
            bus(1'b1, IDX_CTRL, 8'h04);
            bus(1'b1, IDX_MODE, {1'b0, 3'(i % 5), 1'b0, 3'(i % 5)});
            rdchk(IDX_MODE, {25'h0, 3'(i % 5), 1'b0, 3'(i % 5)});
            bus(1'b1, IDX_PRE, {5'h0, n});
            bus(1'b1, IDX_TMR, {5'h0, m});
            rdchk(IDX_TMR, {29'h0, m}); // stopped write
            bus(1'b1, IDX_CTRL, 8'h01);
            wait_irq(); // start
            wait_irq();
            chk(cyc, per(i % 5, n, m)); // period
        end
        // Flags, then a reload change while running
        bus(1'b1, IDX_CTRL, 8'h04);
        bus(1'b1, IDX_PRE, 8'h0F);
        bus(1'b1, IDX_TMR, 8'h0F);
        bus(1'b1, IDX_CTRL, 8'h01);
        wait_irq();
        rdchk(IDX_CTRL, 32'h23); // flag set
        bus(1'b1, IDX_CTRL, 8'h31); // whole word
        rdchk(IDX_CTRL, 32'h23); // one keeps
        bus(1'b1, IDX_CTRL, 8'h01);
        rdchk(IDX_CTRL, 32'h03); // zero clears
        bus(1'b1, IDX_TMR, 8'h03);
        wait_irq();
        wait_irq();
        chk(cyc, per(0, 15, 3)); // reload
        // Forced stop presets and halts
        bus(1'b1, IDX_CTRL, 8'h04);
        rdchk(IDX_CTRL, 32'h0); // cleared
        rdchk(IDX_PRE, 32'hFF); // preset
        rdchk(IDX_TMR, 32'hFF); // preset
        wait_irq();
        chk(cyc, 4000); // halted
        stop_test();
    end
endmodule // prt_timer_top_tb
`default_nettype wire
